//--- include/scps_defs.svh
/*
  offsets, field positions, reset values and timing counts of the
  system clock prescaler and sleep entry block.
  assumes: included by bare name from package and design files.
*/
`ifndef SCPS_DEFS_SVH
`define SCPS_DEFS_SVH

// register byte offsets on the avalon bus
`define SCPS_OFS_PRESCALE    4'h0
`define SCPS_OFS_SLEEP       4'h4
`define SCPS_OFS_TOSC        4'h8
`define SCPS_OFS_STATUS      4'hC

// prescale register fields
`define SCPS_PCE_BIT         7
`define SCPS_SEL_MSB         3
`define SCPS_PCE_UNLOCK      8'h80
`define SCPS_SEL_RST_DIV1    4'h0
`define SCPS_SEL_RST_DIV8    4'h3
`define SCPS_SEL_MAX         4'h8

// sleep control register fields
`define SCPS_SE_BIT          0
`define SCPS_SM_LSB          1
`define SCPS_SM_MSB          3
`define SCPS_SM_IDLE         3'h0
`define SCPS_SM_ADC_NR       3'h1
`define SCPS_SM_PWR_DOWN     3'h2
`define SCPS_SM_PWR_SAVE     3'h3
`define SCPS_SM_STANDBY      3'h6

// timer oscillator register fields
`define SCPS_TOSC_EN_BIT     0
`define SCPS_TOSC_EXT_BIT    1

// timing, in master clock cycles (100 MHz)
`define SCPS_PCE_WINDOW      3'h4
`define SCPS_WAKE_HALT       5'h04
`define SCPS_STARTUP_DEF     5'h06

`endif

//--- include/scps_pkg.sv
/*
  types of the system clock prescaler and sleep entry block.
  assumes: scps_defs.svh on the include path.
*/
`include "scps_defs.svh"

package scps_pkg;

  // sleep sequencer states
  typedef enum logic [1:0] {
    SCPS_RUN,
    SCPS_SLEEP,
    SCPS_WAKE
  } scps_state_t;

  // whole state of the block
  typedef struct packed {
    logic [1:0]  fuse_clock_output_pin_s;    // clock out fuse synchroniser
    logic [1:0]  fuse_div8_s;    // divide-by-eight fuse synchroniser
    logic [1:0]  rc_src_s;       // internal rc source strap synchroniser
    logic [1:0]  tosc_pin_s;     // timer osc input pin synchroniser
    logic        waitreq;        // avalon waitrequest
    logic [31:0] rdata;          // avalon read data
    logic        pce;            // prescale change enable
    logic [2:0]  pce_cnt;        // cycles since pce was set
    logic [3:0]  sel_prog;       // programmed prescale select
    logic [3:0]  sel_act;        // select in force in the divider
    logic [7:0]  div_cnt;        // divider count
    logic        clk_en;         // divided clock enable pulse
    logic        clock_output_pin;           // clock output pin level
    logic        clock_output_pin_oe;        // clock output pin enable
    logic        se;             // sleep enable
    logic [2:0]  sm;             // sleep mode select
    scps_state_t st;             // sleep sequencer state
    logic [4:0]  wake_cnt;       // halt countdown after wake
    logic        halt;           // cpu and flash clocks stopped
    logic        tosc_en;        // timer osc requested
    logic        tosc_ext;       // timer external clock select
    logic        tosc_on;        // timer osc granted
    logic        tosc_ext_on;    // external timer clock granted
    logic        tosc_clk;       // accepted timer clock sample
  } scps_regs_t;

endpackage

//--- hw/scps_top.sv
/*
  system clock prescaler with timed unlock, clock output pin,
  timer oscillator pin control and sleep entry sequencing.
  assumes: one 100 MHz master clock, synchronous active low reset
  held at least 3 edges, a core that strobes sleep instructions and
  wake interrupts on the same clock, fuses and pins asynchronous.
*/
`timescale 1ns/1ps
`include "scps_defs.svh"

// Overview of operation
// - clock out fuse drives pin, even in reset
// - pin carries the divided system clock
// - timer osc only with internal rc source
// - external timer clock needs select bit set
// - divide cpu, flash, io, adc clock enables
// - switch divider only at period boundary
// - new rate within old plus two new periods
// - count runs on master clock, not readable
// - enable set only by write of 0x80
// - enable clears after four cycles or select write
// - rewrite enable neither extends nor clears it
// - reset loads select from divide-by-eight fuse
// - any select value accepted regardless of fuse
// - select codes 0..8 divide by 1..256
// - sleep only with enable bit and instruction
// - wake halts four cycles past startup time
// - register file and sram kept across sleep
// - reset during sleep restarts from reset vector
// - sleep mode codes 0,1,2,3,6 valid only
module scps_top #(
  parameter logic [4:0] STARTUP_CYC = `SCPS_STARTUP_DEF   // oscillator start-up time in cycles
) (
  input  wire logic        I_CLK_SYS,          // undivided master clock
  input  wire logic        I_RST_B,            // synchronous reset, active low
  input  wire logic [3:0]  I_AVS_ADDRESS,      // byte address
  input  wire logic        I_AVS_READ,         // read request
  input  wire logic        I_AVS_WRITE,        // write request
  input  wire logic [31:0] I_AVS_WRITEDATA,    // write data
  output logic      [31:0] O_AVS_READDATA,     // read data
  output logic             O_AVS_WAITREQUEST,  // stall
  input  wire logic        I_FUSE_CLK_OUT,     // clock output fuse programmed
  input  wire logic        I_FUSE_DIV8,        // divide-by-eight fuse programmed
  input  wire logic        I_RC_SOURCE,        // internal rc is system clock
  input  wire logic        I_TOSC_IN_PIN,      // timer osc input pin
  input  wire logic        I_SLEEP_INSTR,      // core executes sleep, one cycle
  input  wire logic        I_WAKE_IRQ,         // enabled interrupt pending
  output logic             O_CLK_EN,           // divided clock enable pulse
  output logic             O_CPU_HALT,         // cpu and flash clocks held
  output logic             O_SLEEPING,         // core in a sleep mode
  output logic      [2:0]  O_SLEEP_MODE,       // mode in force
  output logic             O_CLOCK_OUTPUT_PIN_PIN,         // clock output pin level
  output logic             O_CLOCK_OUTPUT_PIN_OE,          // clock output pin enable
  output logic             O_TOSC_EN,          // timer osc owns crystal pins
  output logic             O_TOSC_EXT_EN,      // external timer clock accepted
  output logic             O_TOSC_CLK          // accepted timer clock sample
);
  import scps_pkg::*;

  scps_regs_t r_r;    // registered state
  scps_regs_t r_nxt;  // next state

  // divide code to terminal count, reserved codes run at 256
  function automatic logic [7:0] div_limit(input logic [3:0] sel);
    logic [8:0] d;
    d = 9'h001;
    if (sel > `SCPS_SEL_MAX) begin
      d = 9'h100;
    end else begin
      d = 9'(9'h001 << sel);
    end
    div_limit = 8'(d - 9'h001);
  endfunction

  // legal sleep mode codes
  function automatic logic sm_valid(input logic [2:0] sm);
    sm_valid = (sm == `SCPS_SM_IDLE) || (sm == `SCPS_SM_ADC_NR) ||
               (sm == `SCPS_SM_PWR_DOWN) || (sm == `SCPS_SM_PWR_SAVE) ||
               (sm == `SCPS_SM_STANDBY);
  endfunction

  logic       bus_req;   // request present
  logic       acc_wr;    // write taken this edge
  logic [7:0] wbyte;     // low write byte
  logic       tick;      // divider terminal count

  assign bus_req = I_AVS_READ || I_AVS_WRITE;
  assign acc_wr  = I_AVS_WRITE && !r_r.waitreq;
  assign wbyte   = I_AVS_WRITEDATA[7:0];
  assign tick    = (r_r.div_cnt == div_limit(r_r.sel_act));

  // next state of everything
  always_comb begin
    r_nxt = r_r;
    // synchronisers, second stage is the only reader of the first
    r_nxt.fuse_clock_output_pin_s = {r_r.fuse_clock_output_pin_s[0], I_FUSE_CLK_OUT};
    r_nxt.fuse_div8_s = {r_r.fuse_div8_s[0], I_FUSE_DIV8};
    r_nxt.rc_src_s    = {r_r.rc_src_s[0], I_RC_SOURCE};
    r_nxt.tosc_pin_s  = {r_r.tosc_pin_s[0], I_TOSC_IN_PIN};
    // pin enable follows the fuse, reset or not
    r_nxt.clock_output_pin_oe = r_r.fuse_clock_output_pin_s[1];

    if (!I_RST_B) begin
      // reset values, fuse loads select
      r_nxt.waitreq  = 1'b1;
      r_nxt.rdata    = 32'h0000_0000;
      r_nxt.pce      = 1'b0;
      r_nxt.pce_cnt  = 3'h0;
      r_nxt.sel_prog = r_r.fuse_div8_s[1] ? `SCPS_SEL_RST_DIV8 : `SCPS_SEL_RST_DIV1;
      r_nxt.sel_act  = r_nxt.sel_prog;
      r_nxt.div_cnt  = 8'h00;
      r_nxt.clk_en   = 1'b0;
      r_nxt.clock_output_pin     = 1'b0;
      r_nxt.se       = 1'b0;
      r_nxt.sm       = `SCPS_SM_IDLE;
      r_nxt.st       = SCPS_RUN;
      r_nxt.wake_cnt = 5'h00;
      r_nxt.halt     = 1'b0;
      r_nxt.tosc_en  = 1'b0;
      r_nxt.tosc_ext = 1'b0;
      r_nxt.tosc_on  = 1'b0;
      r_nxt.tosc_ext_on = 1'b0;
      r_nxt.tosc_clk = 1'b0;
    end else begin
      // bus handshake: one wait cycle, then one ready cycle
      r_nxt.waitreq = !(bus_req && r_r.waitreq);
      if (bus_req && r_r.waitreq) begin
        case (I_AVS_ADDRESS)
          `SCPS_OFS_PRESCALE: begin
            r_nxt.rdata = {24'h00_0000, r_r.pce, 3'h0, r_r.sel_prog};
          end
          `SCPS_OFS_SLEEP: begin
            r_nxt.rdata = {28'h000_0000, r_r.sm, r_r.se};
          end
          `SCPS_OFS_TOSC: begin
            r_nxt.rdata = {30'h0000_0000, r_r.tosc_ext, r_r.tosc_en};
          end
          `SCPS_OFS_STATUS: begin
            r_nxt.rdata = {24'h00_0000, r_r.sel_act, r_r.tosc_ext_on, r_r.tosc_on,
                           r_r.halt, (r_r.st != SCPS_RUN)};
          end
          default: begin
            r_nxt.rdata = 32'h0000_0000;  // unmapped reads zero
          end
        endcase
      end

      // unlock window timeout, counted on the master clock
      if (r_r.pce) begin
        r_nxt.pce_cnt = r_r.pce_cnt + 3'h1;
        if (r_r.pce_cnt == (`SCPS_PCE_WINDOW - 3'h1)) begin
          r_nxt.pce = 1'b0;
        end
      end

      // register writes
      if (acc_wr) begin
        case (I_AVS_ADDRESS)
          `SCPS_OFS_PRESCALE: begin
            if (wbyte == `SCPS_PCE_UNLOCK) begin
              if (!r_r.pce) begin
                r_nxt.pce     = 1'b1;
                r_nxt.pce_cnt = 3'h0;
              end
              // rewrite while open: no restart, no clear
            end else if (r_r.pce && !wbyte[`SCPS_PCE_BIT]) begin
              r_nxt.sel_prog = wbyte[`SCPS_SEL_MSB:0];
              r_nxt.pce      = 1'b0;
            end
            // bits 6..4 are never stored
          end
          `SCPS_OFS_SLEEP: begin
            r_nxt.se = I_AVS_WRITEDATA[`SCPS_SE_BIT];
            r_nxt.sm = I_AVS_WRITEDATA[`SCPS_SM_MSB:`SCPS_SM_LSB];
          end
          `SCPS_OFS_TOSC: begin
            r_nxt.tosc_en  = I_AVS_WRITEDATA[`SCPS_TOSC_EN_BIT];
            r_nxt.tosc_ext = I_AVS_WRITEDATA[`SCPS_TOSC_EXT_BIT];
          end
          default: begin
            r_nxt.se = r_r.se;  // unmapped and read-only writes ignored
          end
        endcase
      end

      // divider, new select taken only at a period boundary
      if (tick) begin
        r_nxt.div_cnt = 8'h00;
        r_nxt.sel_act = r_r.sel_prog;
        r_nxt.clock_output_pin    = !r_r.clock_output_pin;
      end else begin
        r_nxt.div_cnt = r_r.div_cnt + 8'h01;
      end
      r_nxt.clk_en = (r_nxt.div_cnt == div_limit(r_nxt.sel_act));

      // timer oscillator pin ownership
      r_nxt.tosc_on     = r_r.tosc_en && r_r.rc_src_s[1];
      r_nxt.tosc_ext_on = r_nxt.tosc_on && r_r.tosc_ext;
      r_nxt.tosc_clk    = r_nxt.tosc_ext_on && r_r.tosc_pin_s[1];

      // sleep sequencer; memory contents are never touched
      case (r_r.st)
        SCPS_RUN: begin
          if (I_SLEEP_INSTR && r_r.se && sm_valid(r_r.sm)) begin
            r_nxt.st   = SCPS_SLEEP;
            r_nxt.halt = 1'b1;
          end
        end
        SCPS_SLEEP: begin
          if (I_WAKE_IRQ) begin
            r_nxt.st       = SCPS_WAKE;
            r_nxt.wake_cnt = 5'(STARTUP_CYC + `SCPS_WAKE_HALT - 5'h01);
          end
        end
        SCPS_WAKE: begin
          if (r_r.wake_cnt == 5'h00) begin
            r_nxt.st   = SCPS_RUN;
            r_nxt.halt = 1'b0;
          end else begin
            r_nxt.wake_cnt = r_r.wake_cnt - 5'h01;
          end
        end
        default: begin
          r_nxt.st   = SCPS_RUN;
          r_nxt.halt = 1'b0;
        end
      endcase
    end
  end

  // single state register
  always_ff @(posedge I_CLK_SYS) begin
    r_r <= r_nxt;
  end

  // outputs straight from flops, except O_SLEEPING, which is decoded from the state
  assign O_AVS_READDATA    = r_r.rdata;
  assign O_AVS_WAITREQUEST = r_r.waitreq;
  assign O_CLK_EN          = r_r.clk_en;
  assign O_CPU_HALT        = r_r.halt;
  assign O_SLEEPING        = (r_r.st == SCPS_SLEEP);
  assign O_SLEEP_MODE      = r_r.sm;
  assign O_CLOCK_OUTPUT_PIN_PIN        = r_r.clock_output_pin;
  assign O_CLOCK_OUTPUT_PIN_OE         = r_r.clock_output_pin_oe;
  assign O_TOSC_EN         = r_r.tosc_on;
  assign O_TOSC_EXT_EN     = r_r.tosc_ext_on;
  assign O_TOSC_CLK        = r_r.tosc_clk;

  // checks
  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (!I_RST_B);

  a_pce_set_only: assert property ($rose(r_r.pce) |->
    $past(acc_wr && I_AVS_ADDRESS == `SCPS_OFS_PRESCALE && wbyte == `SCPS_PCE_UNLOCK))
    else $error("change enable set without unlock write");

  a_pce_timeout: assert property ($rose(r_r.pce) |-> ##[1:4] !r_r.pce)
    else $error("change enable held past four cycles");

  a_pce_no_early: assert property ($rose(r_r.pce) && !(acc_wr && !wbyte[7]) |=> r_r.pce)
    else $error("change enable cleared early");

  a_sel_locked: assert property ($changed(r_r.sel_prog) |-> $past(r_r.pce))
    else $error("select changed while locked");

  a_sel_reset: assert property (disable iff (1'b0)
    $rose(I_RST_B) |-> r_r.sel_prog == (r_r.fuse_div8_s[1] ? 4'h3 : 4'h0))
    else $error("select reset value wrong");

  a_clock_output_pin_fuse: assert property (disable iff (1'b0) r_r.fuse_clock_output_pin_s[1] |=> O_CLOCK_OUTPUT_PIN_OE)
    else $error("clock pin not enabled by fuse");

  a_div_switch: assert property ($changed(r_r.sel_act) |-> $past(tick))
    else $error("divide changed mid period");

  a_div1_rate: assert property (r_r.sel_act == 4'h0 && r_r.sel_prog == 4'h0 |=> O_CLK_EN)
    else $error("divide by one missed a pulse");

  a_tosc_rc: assert property (O_TOSC_EN |-> $past(r_r.rc_src_s[1]))
    else $error("timer osc granted without rc source");

  a_tosc_ext: assert property (O_TOSC_EXT_EN |-> O_TOSC_EN && $past(r_r.tosc_ext))
    else $error("external timer clock without select");

  a_sleep_entry: assert property ($rose(O_SLEEPING) |-> $past(I_SLEEP_INSTR && r_r.se))
    else $error("sleep without enable and instruction");

  // cycles spent in the wake halt, checks only
  logic [5:0] halt_len_r;

  // count wake cycles, cleared outside the wake state
  always_ff @(posedge I_CLK_SYS) begin
    if (r_r.st == SCPS_WAKE) begin
      halt_len_r <= halt_len_r + 6'h01;
    end else begin
      halt_len_r <= 6'h00;
    end
  end

  a_wake_halt: assert property ($fell(O_CPU_HALT) |->
    halt_len_r == ({1'b0, STARTUP_CYC} + {1'b0, `SCPS_WAKE_HALT}))
    else $error("wake halt length wrong");

endmodule

//--- sim/tb_top.sv
/*
  self-checking bench for the system clock prescaler and sleep entry block.
  assumes: the design's scps_top, scps_pkg and scps_defs.svh compiled first;
  the bench alone drives every input port: fuses, pins, sleep and wake directly, the registers over the avalon bus.
*/
`timescale 1ns/1ps
`include "scps_defs.svh"
module tb_top;
  import scps_pkg::*;
  localparam logic [4:0] STARTUP = 5'h01;       // shortened start-up time
  logic        clk, rst_b, rd, wr, fuse_clock_output_pin, fuse_div8, rc_src, tosc_pin, slp, wake;
  logic [3:0]  addr;                            // bus address
  logic [31:0] wdata, rdata;                    // bus data
  logic        waitreq, clk_en, halt, sleeping, clock_output_pin, clock_output_pin_oe, tosc_en, tosc_ext, tosc_clk;
  logic [2:0]  smode;                           // mode in force
  logic [31:0] q;                               // last read value
  int          error_cnt, checked, n;           // counters

  scps_top #(.STARTUP_CYC(STARTUP)) DUT (
    .I_CLK_SYS(clk), .I_RST_B(rst_b), .I_AVS_ADDRESS(addr), .I_AVS_READ(rd), .I_AVS_WRITE(wr),
    .I_AVS_WRITEDATA(wdata), .O_AVS_READDATA(rdata), .O_AVS_WAITREQUEST(waitreq),
    .I_FUSE_CLK_OUT(fuse_clock_output_pin), .I_FUSE_DIV8(fuse_div8), .I_RC_SOURCE(rc_src),
    .I_TOSC_IN_PIN(tosc_pin), .I_SLEEP_INSTR(slp), .I_WAKE_IRQ(wake), .O_CLK_EN(clk_en),
    .O_CPU_HALT(halt), .O_SLEEPING(sleeping), .O_SLEEP_MODE(smode), .O_CLOCK_OUTPUT_PIN_PIN(clock_output_pin),
    .O_CLOCK_OUTPUT_PIN_OE(clock_output_pin_oe), .O_TOSC_EN(tosc_en), .O_TOSC_EXT_EN(tosc_ext), .O_TOSC_CLK(tosc_clk));

  // 100 MHz master clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // compare seen against expected, count both outcomes
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // one avalon transfer, held until waitrequest is sampled low
  task automatic xfer(input logic w, input logic [3:0] a, input logic [7:0] d);
    int k;
    @(posedge clk);
    wr <= w;
    rd <= ~w;
    addr <= a;
    wdata <= {24'h00_0000, d};
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (waitreq !== 1'b0 && k < 50);
    if (k >= 50) check("bus_answer", 32'h0000_0000, 32'h0000_0001);
    q = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask

  // reset held for five cycles
  task automatic do_reset();
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
  endtask

  // unlock then write the select field; wake stays low across the pair
  task automatic set_sel(input logic [7:0] v);
    xfer(1'b1, `SCPS_OFS_PRESCALE, `SCPS_PCE_UNLOCK);
    xfer(1'b1, `SCPS_OFS_PRESCALE, v);
  endtask

  // wait for the next divided-clock pulse, bounded
  task automatic next_pulse();
    int k;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (clk_en !== 1'b1 && k < 600);
  endtask

  // try one sleep entry; when entered, wake it and measure the halt
  task automatic sleep_try(input logic [2:0] m, input logic se, input logic exp);
    xfer(1'b1, `SCPS_OFS_SLEEP, {4'h0, m, se});
    xfer(1'b0, `SCPS_OFS_SLEEP, 8'h00);
    check("sleep_reg", q, {28'h000_0000, m, se});
    check("sleep_mode", {29'h0, smode}, {29'h0, m});
    @(posedge clk);
    slp <= 1'b1;
    @(posedge clk);
    slp <= 1'b0;
    @(posedge clk);
    #1;
    check("sleeping", {31'h0, sleeping}, {31'h0, exp});
    if (exp) begin
      check("halt_in_sleep", {31'h0, halt}, 32'h0000_0001);
      @(posedge clk);
      wake <= 1'b1;
      n = 0;
      do begin
        @(posedge clk);
        n++;
      end while (halt === 1'b1 && n < 40);
      wake <= 1'b0;
      check("wake_halt_len", {31'h0, n >= STARTUP + 4 && n <= STARTUP + 6}, 32'h0000_0001);
      #1;
      check("awake", {31'h0, sleeping}, 32'h0000_0000);
    end
  endtask

  task automatic print_verdict();
    $display("counts: checked %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // watchdog, well beyond the expected run length
  initial begin
    #(60000 * 10);
    error_cnt++;
    print_verdict();
  end

  // main sequence
  initial begin
    {rd, wr, slp, wake, tosc_pin, rc_src} = '0;
    {fuse_clock_output_pin, fuse_div8} = 2'b11;
    addr = 4'h0;
    wdata = 32'h0000_0000;
    error_cnt = 0;
    checked = 0;
    rst_b = 1'b0;
    repeat (5) @(posedge clk);
    check("clock_output_pin_oe_reset", {31'h0, clock_output_pin_oe}, 32'h0000_0001);
    rst_b <= 1'b1;
    xfer(1'b0, `SCPS_OFS_PRESCALE, 8'h00);
    check("sel_reset_div8", q, 32'h0000_0003);
    $display("test reset values done");
    // locked, malformed unlock, timeout and rewrite cases
    xfer(1'b1, `SCPS_OFS_PRESCALE, 8'h05);
    xfer(1'b1, `SCPS_OFS_PRESCALE, 8'h81);
    xfer(1'b1, `SCPS_OFS_PRESCALE, 8'h01);
    xfer(1'b0, `SCPS_OFS_PRESCALE, 8'h00);
    check("sel_locked", q, 32'h0000_0003);
    xfer(1'b1, `SCPS_OFS_PRESCALE, `SCPS_PCE_UNLOCK);
    xfer(1'b0, `SCPS_OFS_PRESCALE, 8'h00);
    check("pce_open", q, 32'h0000_0083);
    repeat (4) @(posedge clk);
    xfer(1'b1, `SCPS_OFS_PRESCALE, 8'h02);
    xfer(1'b0, `SCPS_OFS_PRESCALE, 8'h00);
    check("pce_timeout", q, 32'h0000_0003);
    xfer(1'b1, `SCPS_OFS_PRESCALE, `SCPS_PCE_UNLOCK);
    xfer(1'b1, `SCPS_OFS_PRESCALE, `SCPS_PCE_UNLOCK);
    xfer(1'b1, `SCPS_OFS_PRESCALE, 8'h02);
    xfer(1'b0, `SCPS_OFS_PRESCALE, 8'h00);
    check("pce_no_extend", q, 32'h0000_0003);
    set_sel(8'h7F);
    xfer(1'b0, `SCPS_OFS_PRESCALE, 8'h00);
    check("sel_reserved", q, 32'h0000_000F);
    xfer(1'b0, 4'h2, 8'h00);
    check("unmapped", q, 32'h0000_0000);
    $display("test unlock sequence done");
    // every division code: pulse spacing, pin toggle, active select
    for (int k = 0; k <= 8; k++) begin
      set_sel(k[7:0]);
      xfer(1'b0, `SCPS_OFS_PRESCALE, 8'h00);
      check("sel_written", q, k);
      next_pulse();
      next_pulse();
      next_pulse();
      tosc_pin <= tosc_pin;
      q[0] = clock_output_pin;
      n = 0;
      do begin
        @(posedge clk);
        n++;
      end while (clk_en !== 1'b1 && n < 600);
      check("div_period", n, 32'h0000_0001 << k);
      check("clock_output_pin_toggle", {31'h0, clock_output_pin ^ q[0]}, 32'h0000_0001);
      xfer(1'b0, `SCPS_OFS_STATUS, 8'h00);
      check("active_sel", {28'h0, q[7:4]}, k);
    end
    $display("test division codes done");
    // sleep entry for every valid mode, reserved mode and disabled entry
    sleep_try(3'd0, 1'b1, 1'b1);
    sleep_try(3'd1, 1'b1, 1'b1);
    sleep_try(3'd2, 1'b1, 1'b1);
    sleep_try(3'd3, 1'b1, 1'b1);
    sleep_try(3'd6, 1'b1, 1'b1);
    sleep_try(3'd4, 1'b1, 1'b0);
    sleep_try(3'd2, 1'b0, 1'b0);
    $display("test sleep modes done");
    // timer oscillator grant
    xfer(1'b1, `SCPS_OFS_TOSC, 8'h03);
    tosc_pin <= 1'b1;
    repeat (4) @(posedge clk);
    check("tosc_no_rc", {30'h0, tosc_en, tosc_ext}, 32'h0000_0000);
    rc_src <= 1'b1;
    repeat (4) @(posedge clk);
    check("tosc_rc", {29'h0, tosc_en, tosc_ext, tosc_clk}, 32'h0000_0007);
    xfer(1'b1, `SCPS_OFS_TOSC, 8'h01);
    repeat (4) @(posedge clk);
    check("tosc_no_ext", {29'h0, tosc_en, tosc_ext, tosc_clk}, 32'h0000_0004);
    $display("test timer oscillator done");
    // reset during sleep, with the divide fuse now clear
    sleep_try(3'd2, 1'b1, 1'b0 | 1'b1);
    xfer(1'b1, `SCPS_OFS_SLEEP, 8'h05);
    @(posedge clk);
    slp <= 1'b1;
    @(posedge clk);
    slp <= 1'b0;
    fuse_div8 <= 1'b0;
    repeat (2) @(posedge clk);
    do_reset();
    @(posedge clk);
    #1;
    check("reset_wakes", {30'h0, sleeping, halt}, 32'h0000_0000);
    xfer(1'b0, `SCPS_OFS_PRESCALE, 8'h00);
    check("sel_reset_div1", q, 32'h0000_0000);
    $display("test reset in sleep done");
    print_verdict();
  end
endmodule
